// file: hdl/ccs_pkg.sv
/*
  Package for the comparator control and status register block.
  Assumes an AHB-Lite slave with 32-bit data and one register word.
*/
`default_nettype none
package ccs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] CCS_ADDR_CSR   = 12'h01C;
  localparam logic [31:0] CCS_CSR_RESET  = 32'h00000000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CCS_A_ON      = 0;
  localparam int CCS_A_SW      = 1;
  localparam int CCS_A_SPD_LO  = 2;
  localparam int CCS_A_MIN_LO  = 4;
  localparam int CCS_A_RTE_LO  = 8;
  localparam int CCS_A_FLIP    = 11;
  localparam int CCS_A_HYS_LO  = 12;
  localparam int CCS_A_RESULT  = 14;
  localparam int CCS_A_FREEZE  = 15;
  localparam int CCS_B_ON      = 16;
  localparam int CCS_B_SPD_LO  = 18;
  localparam int CCS_B_MIN_LO  = 20;
  localparam int CCS_WIN_JOIN  = 23;
  localparam int CCS_B_RTE_LO  = 24;
  localparam int CCS_B_FLIP    = 27;
  localparam int CCS_B_HYS_LO  = 28;
  localparam int CCS_B_RESULT  = 30;
  localparam int CCS_B_FREEZE  = 31;

  // Writable control bits of each comparator (results excluded).
  localparam logic [31:0] CCS_A_CTRL_MASK = 32'h00003F7F;
  localparam logic [31:0] CCS_B_CTRL_MASK = 32'h3FFD0000;
  localparam logic [31:0] CCS_B_OWN_MASK  = 32'h3F7D0000;

  // ****************************************************************
  // Route and source encodings
  // ****************************************************************
  localparam logic [2:0] CCS_RTE_NONE     = 3'h0;
  localparam logic [2:0] CCS_RTE_ADV_BRK  = 3'h1;
  localparam logic [2:0] CCS_RTE_ADV_CAP1 = 3'h2;
  localparam logic [2:0] CCS_RTE_ADV_CLR  = 3'h3;
  localparam logic [2:0] CCS_RTE_GA_CAP4  = 3'h4;
  localparam logic [2:0] CCS_RTE_GA_CLR   = 3'h5;
  localparam logic [2:0] CCS_RTE_GB_CAP1  = 3'h6;
  localparam logic [2:0] CCS_MIN_RSVD     = 3'h7;

  localparam int CCS_NUM_DEST = 6;

  // AHB encodings.
  localparam logic [1:0] CCS_HTRANS_NSEQ = 2'h2;
  localparam logic [1:0] CCS_HTRANS_SEQ  = 2'h3;

endpackage
`default_nettype wire

// file: hdl/ccs_sync.sv
/*
  Three-stage synchroniser with agreement filter for asynchronous inputs.
  Assumes the input is a level from outside the clock domain.
*/
`timescale 1ns/1ns
`default_nettype none
module ccs_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  // Data
  input  wire logic async_in,
  output var  logic sync_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } ccs_sync_s;

  ccs_sync_s st_r;
  ccs_sync_s st_nxt;

  // ****************************************************************
  // Filter
  // ****************************************************************
  // The first stage is only read by the second; a change counts once
  // the second and third agree.
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = async_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (st_r.s2 == st_r.s3) begin
      st_nxt.q = st_r.s3;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '{RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.q;

endmodule
`default_nettype wire

// file: hdl/ccs_regs.sv
/*
  Control and status register for two analog comparators, with AHB-Lite
  slave, output polarity, synchronisers and timer routing.
  Assumes raw comparator outputs arrive asynchronously from the analog
  macros and that resetn_in is the system reset.
*/
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Comparator A route field: 0 none, 1..6 timer destinations.
// - Comparator A flip bit inverts its output before routing, status.
// - Comparator A hysteresis field picks none, low, medium, high.
// - Comparator A result reads high when compare, after flip, is high.
// - Comparator A freeze set once, cleared by reset, locks its controls.
// - Comparator B on bit switches comparator B on or off.
// - Comparator B speed field picks four speed and power levels.
// - Comparator B minus source: reference fractions, pins; 111 reserved.
// - Window join bit ties both plus inputs together.
// - Comparator B route field uses comparator A encoding.
// - Comparator B flip bit inverts comparator B output.
// - Comparator B hysteresis field picks none, low, medium, high.
// - Comparator B result reflects comparison after flip.
// - Comparator B freeze set once, cleared by reset, locks controls.
// - Comparator A on bit switches comparator A on or off.
// - Comparator A speed field picks four speed and power levels.
// - Comparator A minus source uses comparator B encoding.
// - Outputs synchronised to bus clock; only system reset clears.
module ccs_regs (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        resetn_in,
  // AHB-Lite slave
  input  wire logic        hsel_in,
  input  wire logic [11:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output var  logic [31:0] hrdata_out,
  output var  logic        hreadyout_out,
  output var  logic        hresp_out,
  // Raw analog comparator outputs
  input  wire logic        cmp_a_raw_in,
  input  wire logic        cmp_b_raw_in,
  // Analog control for comparator A
  output var  logic        cmp_a_on_out,
  output var  logic        cmp_a_dac_switch_out,
  output var  logic [1:0]  cmp_a_speed_power_out,
  output var  logic [2:0]  cmp_a_minus_source_out,
  output var  logic [1:0]  cmp_a_hysteresis_out,
  // Analog control for comparator B
  output var  logic        cmp_b_on_out,
  output var  logic [1:0]  cmp_b_speed_power_out,
  output var  logic [2:0]  cmp_b_minus_source_out,
  output var  logic [1:0]  cmp_b_hysteresis_out,
  output var  logic        window_join_out,
  // Timer inputs: 0 advanced break, 1 advanced capture 1,
  // 2 advanced clear, 3 timer A capture 4, 4 timer A clear,
  // 5 timer B capture 1
  output var  logic [5:0]  cmp_a_dest_out,
  output var  logic [5:0]  cmp_b_dest_out,
  // Synchronised, polarity-corrected outputs
  output var  logic        cmp_a_level_out,
  output var  logic        cmp_b_level_out
);

  typedef struct packed {
    logic [31:0] csr;
    logic        wr_pend;
    logic [11:0] addr;
    logic [31:0] rdata;
    logic [5:0]  dest_a;
    logic [5:0]  dest_b;
  } ccs_regs_s;

  ccs_regs_s st_r;
  ccs_regs_s st_nxt;

  logic sync_a;
  logic sync_b;
  logic lvl_a;
  logic lvl_b;
  logic take;
  logic [31:0] wmask;
  logic [31:0] merged;

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  // bus clock synchronisers
  ccs_sync #(
    .RESET_VAL (1'b0)
  ) u_sync_a (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (cmp_a_raw_in),
    .sync_out   (sync_a)
  );

  ccs_sync #(
    .RESET_VAL (1'b0)
  ) u_sync_b (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .async_in   (cmp_b_raw_in),
    .sync_out   (sync_b)
  );

  assign lvl_a = sync_a ^ st_r.csr[ccs_pkg::CCS_A_FLIP];
  assign lvl_b = sync_b ^ st_r.csr[ccs_pkg::CCS_B_FLIP];

  // Decodes a route field into one-hot timer inputs. Code zero and
  // the unused code drive nothing.
  function automatic logic [5:0] route_dec(input logic [2:0] sel,
                                           input logic       lvl);
    logic [5:0] d;
    d = 6'h00;
    if (sel != ccs_pkg::CCS_RTE_NONE && sel <= ccs_pkg::CCS_RTE_GB_CAP1) begin
      d[sel - 3'h1] = lvl;
    end
    return d;
  endfunction

  // ****************************************************************
  // Bus and register update
  // ****************************************************************
  assign take = hsel_in && hready_in &&
                (htrans_in == ccs_pkg::CCS_HTRANS_NSEQ ||
                 htrans_in == ccs_pkg::CCS_HTRANS_SEQ);

  always_comb begin
    wmask = 32'h00000000;
    if (!st_r.csr[ccs_pkg::CCS_A_FREEZE]) begin
      wmask = wmask | ccs_pkg::CCS_A_CTRL_MASK;
    end
    if (!st_r.csr[ccs_pkg::CCS_B_FREEZE]) begin
      wmask = wmask | ccs_pkg::CCS_B_OWN_MASK;
      // Window join belongs to comparator B's control set.
      wmask[ccs_pkg::CCS_WIN_JOIN] = 1'b1;
    end
    merged = (st_r.csr & ~wmask) | (hwdata_in & wmask);
    // Freeze bits set only; writing zero never clears them.
    merged[ccs_pkg::CCS_A_FREEZE] = st_r.csr[ccs_pkg::CCS_A_FREEZE] |
                                    hwdata_in[ccs_pkg::CCS_A_FREEZE];
    merged[ccs_pkg::CCS_B_FREEZE] = st_r.csr[ccs_pkg::CCS_B_FREEZE] |
                                    hwdata_in[ccs_pkg::CCS_B_FREEZE];
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_pend = 1'b0;
    if (st_r.wr_pend && st_r.addr[11:2] == ccs_pkg::CCS_ADDR_CSR[11:2]) begin
      st_nxt.csr = merged;
    end
    if (take) begin
      st_nxt.wr_pend = hwrite_in;
      st_nxt.addr    = haddr_in;
    end
    st_nxt.csr[ccs_pkg::CCS_A_RESULT] = lvl_a;
    st_nxt.csr[ccs_pkg::CCS_B_RESULT] = lvl_b;
    st_nxt.rdata = 32'h00000000;
    if (take && !hwrite_in &&
        haddr_in[11:2] == ccs_pkg::CCS_ADDR_CSR[11:2]) begin
      st_nxt.rdata = st_r.csr;
      st_nxt.rdata[ccs_pkg::CCS_A_RESULT] = lvl_a;
      st_nxt.rdata[ccs_pkg::CCS_B_RESULT] = lvl_b;
    end
    st_nxt.dest_a = route_dec(
      st_r.csr[ccs_pkg::CCS_A_RTE_LO +: 3], lvl_a);
    st_nxt.dest_b = route_dec(
      st_r.csr[ccs_pkg::CCS_B_RTE_LO +: 3], lvl_b);
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      st_r <= '{ccs_pkg::CCS_CSR_RESET, 1'b0, 12'h000, 32'h00000000,
                6'h00, 6'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata_out    = st_r.rdata;
  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;

  assign cmp_a_on_out           = st_r.csr[ccs_pkg::CCS_A_ON];
  assign cmp_a_dac_switch_out   = st_r.csr[ccs_pkg::CCS_A_SW];
  assign cmp_a_speed_power_out  = st_r.csr[ccs_pkg::CCS_A_SPD_LO +: 2];
  assign cmp_a_minus_source_out = st_r.csr[ccs_pkg::CCS_A_MIN_LO +: 3];
  assign cmp_a_hysteresis_out   = st_r.csr[ccs_pkg::CCS_A_HYS_LO +: 2];
  assign cmp_b_on_out           = st_r.csr[ccs_pkg::CCS_B_ON];
  assign cmp_b_speed_power_out  = st_r.csr[ccs_pkg::CCS_B_SPD_LO +: 2];
  assign cmp_b_minus_source_out = st_r.csr[ccs_pkg::CCS_B_MIN_LO +: 3];
  assign cmp_b_hysteresis_out   = st_r.csr[ccs_pkg::CCS_B_HYS_LO +: 2];
  assign window_join_out        = st_r.csr[ccs_pkg::CCS_WIN_JOIN];
  assign cmp_a_dest_out         = st_r.dest_a;
  assign cmp_b_dest_out         = st_r.dest_b;
  assign cmp_a_level_out        = st_r.csr[ccs_pkg::CCS_A_RESULT];
  assign cmp_b_level_out        = st_r.csr[ccs_pkg::CCS_B_RESULT];

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);

  chk_freeze_a_sticky: assert property (
    $rose(st_r.csr[ccs_pkg::CCS_A_FREEZE]) |=>
      st_r.csr[ccs_pkg::CCS_A_FREEZE] [*8])
    else $error("Comparator A freeze dropped");

  chk_freeze_b_sticky: assert property (
    st_r.csr[ccs_pkg::CCS_B_FREEZE] |=> st_r.csr[ccs_pkg::CCS_B_FREEZE])
    else $error("Comparator B freeze dropped");

  chk_frozen_a_hold: assert property (
    st_r.csr[ccs_pkg::CCS_A_FREEZE] |=>
      $stable(st_r.csr & ccs_pkg::CCS_A_CTRL_MASK))
    else $error("Frozen comparator A control changed");

  chk_frozen_b_hold: assert property (
    st_r.csr[ccs_pkg::CCS_B_FREEZE] |=>
      $stable(st_r.csr[ccs_pkg::CCS_B_HYS_LO +: 2]) &&
      $stable(st_r.csr[ccs_pkg::CCS_B_RTE_LO +: 4]) &&
      $stable(st_r.csr[ccs_pkg::CCS_WIN_JOIN]))
    else $error("Frozen comparator B control changed");

  chk_result_a_flip: assert property (
    cmp_a_level_out == $past(sync_a ^ st_r.csr[ccs_pkg::CCS_A_FLIP]))
    else $error("Comparator A result wrong");

  chk_result_b_flip: assert property (
    cmp_b_level_out == $past(sync_b ^ st_r.csr[ccs_pkg::CCS_B_FLIP]))
    else $error("Comparator B result wrong");

  chk_route_a_none: assert property (
    $past(st_r.csr[ccs_pkg::CCS_A_RTE_LO +: 3]) == ccs_pkg::CCS_RTE_NONE
      |-> cmp_a_dest_out == 6'h00)
    else $error("Comparator A routed while none selected");

  chk_route_b_cap: assert property (
    $past(st_r.csr[ccs_pkg::CCS_B_RTE_LO +: 3]) ==
      ccs_pkg::CCS_RTE_GB_CAP1 |-> cmp_b_dest_out[5] == $past(lvl_b))
    else $error("Comparator B timer B capture wrong");

  chk_write_lands: assert property (
    take && hwrite_in && !st_r.csr[ccs_pkg::CCS_A_FREEZE] &&
    haddr_in[11:2] == ccs_pkg::CCS_ADDR_CSR[11:2] ##1
      !st_r.csr[ccs_pkg::CCS_A_FREEZE] |=>
      cmp_a_on_out == $past(hwdata_in[ccs_pkg::CCS_A_ON]))
    else $error("Comparator A enable write lost");

  cov_freeze_a: cover property (
    $rose(st_r.csr[ccs_pkg::CCS_A_FREEZE]));
  cov_window: cover property ($rose(window_join_out));
  cov_route_b: cover property (cmp_b_dest_out != 6'h00);
  cov_result_a: cover property ($rose(cmp_a_level_out));

endmodule
`default_nettype wire

// file: dv/ccs_timer_model.sv
/*
  Timer-side model: latches the routed comparator levels at the timer inputs.
  Assumes the routed vectors are synchronous to the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module ccs_timer_model (
  // Clock and reset
  input  wire logic       clk_sys_in,
  input  wire logic       resetn_in,
  // Routed comparator levels
  input  wire logic [5:0] dest_a_in,
  input  wire logic [5:0] dest_b_in,
  // Levels as the timers latched them
  output var  logic [5:0] seen_a_out,
  output var  logic [5:0] seen_b_out
);
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seen_a_out <= 6'h00;
      seen_b_out <= 6'h00;
    end else begin
      seen_a_out <= dest_a_in;
      seen_b_out <= dest_b_in;
    end
  end
endmodule
`default_nettype wire

// file: dv/comparator_control_status_bench.sv
/*
  Self-checking bench for the comparator register block with timer model.
  Assumes zero-wait AHB-Lite slave and a few cycles of output synchroniser.
*/
`timescale 1ns/1ns
`default_nettype none
module comparator_control_status_bench;
  logic        clk_sys_in = 1'b0;
  logic        resetn_in  = 1'b0;
  logic        hsel_in    = 1'b0;
  logic        hwrite_in  = 1'b0;
  logic        raw_a      = 1'b0;
  logic        raw_b      = 1'b0;
  logic [11:0] haddr_in   = 12'h000;
  logic [1:0]  htrans_in  = 2'h0;
  logic [31:0] hwdata_in  = 32'h00000000;
  logic [31:0] hrdata_out, sh, rd, w;
  logic        hreadyout_out, hresp_out, a_on, a_sw, b_on, win, lvl_a, lvl_b;
  logic [1:0]  a_spd, a_hys, b_spd, b_hys;
  logic [2:0]  a_min, b_min;
  logic [5:0]  dest_a, dest_b, seen_a, seen_b;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          seed       = 85;
  int          i;

  ccs_regs dut_u (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hsize_in(3'h2), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .cmp_a_raw_in(raw_a), .cmp_b_raw_in(raw_b), .cmp_a_on_out(a_on),
    .cmp_a_dac_switch_out(a_sw), .cmp_a_speed_power_out(a_spd),
    .cmp_a_minus_source_out(a_min), .cmp_a_hysteresis_out(a_hys),
    .cmp_b_on_out(b_on), .cmp_b_speed_power_out(b_spd),
    .cmp_b_minus_source_out(b_min), .cmp_b_hysteresis_out(b_hys),
    .window_join_out(win), .cmp_a_dest_out(dest_a),
    .cmp_b_dest_out(dest_b), .cmp_a_level_out(lvl_a),
    .cmp_b_level_out(lvl_b));

  ccs_timer_model tmr_u (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
    .dest_a_in(dest_a), .dest_b_in(dest_b), .seen_a_out(seen_a),
    .seen_b_out(seen_b));

  // ****************************************************************
  // Expectations and bus tasks
  // ****************************************************************
  function automatic logic [5:0] exp_dest(input logic [2:0] rte,
                                          input logic lvl);
    exp_dest = 6'h00;
    if (rte != 3'h0 && rte != 3'h7) exp_dest[rte - 3'h1] = lvl;
  endfunction

  task automatic finish_test;
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask

  // Every wait is bounded so a stuck slave ends the run instead of hanging.
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (hreadyout_out !== 1'b1 && n < 50);
    if (hreadyout_out !== 1'b1) begin
      $display("BAD hready expected 1 seen %b", hreadyout_out);
      n_mismatch++;
      finish_test;
    end
  endtask

  task automatic bus(input logic [11:0] a, input logic wr_en,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys_in);
    hsel_in <= 1'b1;
    haddr_in <= a;
    htrans_in <= ccs_pkg::CCS_HTRANS_NSEQ;
    hwrite_in <= wr_en;
    wait_rdy;
    hsel_in <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    wait_rdy;
    r = hrdata_out;
    chk("hresp", 32'h00000000, {31'h0, hresp_out});
  endtask

  task automatic wr(input logic [31:0] v);
    logic [31:0] m;
    m = (sh[15] ? 32'h00000000 : ccs_pkg::CCS_A_CTRL_MASK) |
        (sh[31] ? 32'h00000000 : ccs_pkg::CCS_B_CTRL_MASK);
    sh = (sh & ~m) | (v & m);
    sh[15] = sh[15] | v[15];
    sh[31] = sh[31] | v[31];
    bus(ccs_pkg::CCS_ADDR_CSR, 1'b1, v, rd);
  endtask

  task automatic check_all;
    logic [31:0] e;
    repeat (8) @(posedge clk_sys_in);
    e = sh;
    e[14] = raw_a ^ sh[11];
    e[30] = raw_b ^ sh[27];
    bus(ccs_pkg::CCS_ADDR_CSR, 1'b0, 32'h00000000, rd);
    chk("csr", e, rd);
    chk("a_fields", {23'h0, e[13:12], e[6:4], e[3:0]},
        {23'h0, a_hys, a_min, a_spd, a_sw, a_on});
    chk("b_fields", {23'h0, e[29:28], e[19:18], e[22:20], e[23], e[16]},
        {23'h0, b_hys, b_spd, b_min, win, b_on});
    chk("levels", {30'h0, e[30], e[14]}, {30'h0, lvl_b, lvl_a});
    chk("dest", {20'h0, exp_dest(e[26:24], e[30]), exp_dest(e[10:8], e[14])},
        {20'h0, seen_b, seen_a});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    sh = 32'h00000000;
    repeat (20) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    check_all;
    bus(12'h018, 1'b1, 32'hFFFFFFFF, rd);
    bus(12'h020, 1'b0, 32'h00000000, rd);
    chk("unmapped", 32'h00000000, rd);
    raw_b <= 1'b1;
    for (i = 0; i < 8; i++) begin
      wr(32'h00010801 | (32'(i) << 8) | (32'(i) << 24));
      check_all;
    end
    for (i = 0; i < 24; i++) begin
      w = $random(seed);
      raw_a <= w[0];
      raw_b <= w[1];
      w = $random(seed);
      wr(w & 32'h7FFF7FFF);
      check_all;
    end
    wr(sh | 32'h00008000);
    wr(~sh & 32'h7FFF7FFF);
    check_all;
    wr(sh | 32'h80000000);
    wr(~sh & 32'h7FFF7FFF);
    check_all;
    raw_a <= ~raw_a;
    raw_b <= ~raw_b;
    check_all;
    resetn_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    resetn_in <= 1'b1;
    sh = 32'h00000000;
    check_all;
    wr(32'h3F7D3F7F);
    check_all;
    finish_test;
  end
endmodule
`default_nettype wire
